// *** src/modem_status_regs.sv ***
// modem status, scratch swap, fifo level readout, divisor and auto flow control
module modem_status_regs
    import modem_status_pkg::*;
#(
    parameter int LEVEL_W = 8
) (
    input  wire logic              REF_CLK_IN,
    input  wire logic              RESET_IN,
    input  wire logic [2:0]        ADDR_IN,
    input  wire logic              WR_IN,
    input  wire logic              RD_IN,
    input  wire logic [7:0]        WDATA_IN,
    output logic [7:0]             RDATA_OUT,
    input  wire logic [7:0]        LINE_CONTROL_IN,
    input  wire logic [7:0]        MODEM_CONTROL_IN,
    input  wire logic [7:0]        INTERRUPT_ENABLE_IN,
    input  wire logic [7:0]        FEATURE_CONTROL_IN,
    input  wire logic [7:0]        EXTENDED_FEATURE_CONTROL_IN,
    input  wire logic              CTS_N_IN,
    input  wire logic              DSR_N_IN,
    input  wire logic              RI_N_IN,
    input  wire logic              CD_N_IN,
    input  wire logic [LEVEL_W-1:0] RX_LEVEL_IN,
    input  wire logic [LEVEL_W-1:0] TX_LEVEL_IN,
    input  wire logic [LEVEL_W-1:0] RX_TRIGGER_IN,
    input  wire logic              RX_ERR_PUSH_IN,
    input  wire logic              RX_ERR_POP_IN,
    input  wire logic              RX_FLUSH_IN,
    input  wire logic              TX_CHAR_DONE_IN,
    output logic                   ERROR_SUMMARY_OUT,
    output logic                   MODEM_IRQ_OUT,
    output logic                   TX_HALT_OUT,
    output logic                   RTS_N_OUT,
    output logic                   BAUD_TICK_OUT,
    output logic [15:0]            DIVISOR_OUT,
    output logic [7:0]             HYSTERESIS_OUT
);
    // the level readout is one byte wide, so wider counts cannot be served
    if (LEVEL_W < 1 || LEVEL_W > 8) begin
        $error("LEVEL_W must lie in 1..8");
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic byte_t hyst_of(input logic [3:0] code);  // see RULE_15
        case (code)
            4'h0:    hyst_of = 8'h00;
            4'h1:    hyst_of = 8'h04;
            4'h2:    hyst_of = 8'h06;
            4'h3:    hyst_of = 8'h08;
            4'h4:    hyst_of = 8'h08;
            4'h5:    hyst_of = 8'h10;
            4'h6:    hyst_of = 8'h18;
            4'h7:    hyst_of = 8'h20;
            4'h8:    hyst_of = 8'h28;
            4'h9:    hyst_of = 8'h2C;
            4'hA:    hyst_of = 8'h30;
            4'hB:    hyst_of = 8'h34;
            4'hC:    hyst_of = 8'h0C;
            4'hD:    hyst_of = 8'h14;
            4'hE:    hyst_of = 8'h1C;
            default: hyst_of = 8'h24;
        endcase
    endfunction

    function automatic byte_t widen(input logic [LEVEL_W-1:0] v);
        widen = 8'(v);
    endfunction

    typedef enum logic [1:0] {
        PICK_RX = 2'b01,
        PICK_TX = 2'b10
    } pick_e;

    typedef struct packed {
        logic [3:0] lines;      // last sampled cts, dsr, ri, cd (true sense)
        logic [3:0] delta;
        byte_t      scratch;
        byte_t      emode;
        byte_t      div_lo;
        byte_t      div_hi;
        pick_e      pick;
        logic [8:0] err_count;
        logic       cts_hold;
        logic       rts_off;
        byte_t      rdata;
    } regs_s;

    regs_s st;
    regs_s next_st;
    logic  loopback;
    logic  swap;
    logic  div_access;
    logic [3:0] now_lines;
    logic [3:0] status_hi;
    byte_t rx_lvl;
    byte_t tx_lvl;
    byte_t trig;
    byte_t hyst;
    logic [8:0] upper;
    logic [8:0] lower;
    logic [1:0] cmode;

    always_comb begin
        loopback   = MODEM_CONTROL_IN[MCTL_LOOP];
        swap       = FEATURE_CONTROL_IN[FCTL_SWAP];
        div_access = LINE_CONTROL_IN[LCTL_DIV];
        // status bits: cts, dsr, ri, cd in true (active high) sense
        if (loopback) begin
            status_hi = {MODEM_CONTROL_IN[MCTL_OUT2], MODEM_CONTROL_IN[MCTL_OUT1],
                         MODEM_CONTROL_IN[MCTL_DTR], MODEM_CONTROL_IN[MCTL_RTS]};
        end else begin
            status_hi = {~CD_N_IN, ~RI_N_IN, ~DSR_N_IN, ~CTS_N_IN};  // see RULE_06 RULE_07
        end                                                       // see RULE_08 RULE_09
        now_lines = {status_hi[0], status_hi[1], status_hi[2], status_hi[3]};
        rx_lvl = widen(RX_LEVEL_IN);
        tx_lvl = widen(TX_LEVEL_IN);
        trig   = widen(RX_TRIGGER_IN);
        hyst   = hyst_of({st.emode[5:4], FEATURE_CONTROL_IN[1:0]});
        upper  = {1'b0, trig} + {1'b0, hyst};
        lower  = {1'b0, trig} - {1'b0, hyst};
        cmode  = st.emode[1:0];

        next_st = st;
        next_st.lines = now_lines;
        // change flags: read clears, but a fresh change in the same cycle wins
        if (RD_IN && ADDR_IN == ADDR_MSTAT) begin
            next_st.delta = 4'h0;  // see RULE_20
        end
        // lines order: cts[3], dsr[2], ri[1], cd[0]
        if (now_lines[3] != st.lines[3]) next_st.delta[0] = 1'b1;  // see RULE_02
        if (now_lines[2] != st.lines[2]) next_st.delta[1] = 1'b1;  // see RULE_02
        if (now_lines[0] != st.lines[0]) next_st.delta[3] = 1'b1;  // see RULE_02
        // ri true sense falling means the pin rose, the end of a ring
        if (st.lines[1] && !now_lines[1]) next_st.delta[2] = 1'b1;  // see RULE_03

        // error tag counter tracks tagged bytes held in the receive fifo
        if (RX_FLUSH_IN) begin
            next_st.err_count = 9'h000;
        end else if (RX_ERR_PUSH_IN && !RX_ERR_POP_IN) begin
            next_st.err_count = st.err_count + 9'h001;  // see RULE_01
        end else if (RX_ERR_POP_IN && !RX_ERR_PUSH_IN && st.err_count != 9'h000) begin
            next_st.err_count = st.err_count - 9'h001;  // see RULE_01
        end

        // auto cts: a halt is taken only at a character boundary so the current one completes;
        // a held transmitter sends nothing more, so release follows cts directly
        if (!EXTENDED_FEATURE_CONTROL_IN[EXT_AUTO_CTS]) begin
            next_st.cts_hold = 1'b0;
        end else if (st.cts_hold || TX_CHAR_DONE_IN) begin
            next_st.cts_hold = CTS_N_IN;  // see RULE_05
        end

        // auto rts hysteresis window
        if (!EXTENDED_FEATURE_CONTROL_IN[EXT_AUTO_RTS]) begin
            next_st.rts_off = 1'b0;
        end else if (!st.rts_off && {1'b0, rx_lvl} >= upper) begin
            next_st.rts_off = 1'b1;  // see RULE_19
        end else if (st.rts_off && (!lower[8]) && {1'b0, rx_lvl} < lower) begin
            next_st.rts_off = 1'b0;  // see RULE_19
        end

        // register writes
        if (WR_IN) begin
            if (ADDR_IN == ADDR_DATA && div_access) begin
                next_st.div_lo = WDATA_IN;  // see RULE_17
            end
            if (ADDR_IN == ADDR_IEN && div_access) begin
                next_st.div_hi = WDATA_IN;  // see RULE_17
            end
            if (ADDR_IN == ADDR_SCRATCH) begin
                if (swap) begin
                    next_st.emode = WDATA_IN;  // see RULE_11
                    next_st.pick  = PICK_RX;   // see RULE_21
                end else begin
                    next_st.scratch = WDATA_IN;  // see RULE_10
                end
            end
        end

        // register reads, data held in a flip-flop
        next_st.rdata = ZERO_BYTE;
        if (RD_IN) begin
            case (ADDR_IN)
                ADDR_DATA:    next_st.rdata = div_access ? st.div_lo : ZERO_BYTE;
                ADDR_IEN:     next_st.rdata = div_access ? st.div_hi : ZERO_BYTE;
                ADDR_LSTAT:   next_st.rdata = {(st.err_count != 9'h000), 7'h00};
                ADDR_MSTAT:   next_st.rdata = {status_hi[3], status_hi[2], status_hi[1],
                                               status_hi[0], st.delta};
                ADDR_SCRATCH: begin
                    if (!swap) begin
                        next_st.rdata = st.scratch;
                    end else begin
                        case (cmode)  // see RULE_12 RULE_14
                            MODE_TX:  next_st.rdata = tx_lvl;
                            MODE_ALT: begin
                                case (st.pick)  // see RULE_13
                                    PICK_TX: next_st.rdata = tx_lvl;
                                    default: next_st.rdata = rx_lvl;
                                endcase
                                next_st.pick = (st.pick == PICK_RX) ? PICK_TX : PICK_RX;
                            end
                            default:  next_st.rdata = rx_lvl;
                        endcase
                    end
                end
                default:      next_st.rdata = ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            st         <= '0;
            st.scratch <= SCRATCH_RESET;  // see RULE_10
            st.pick    <= PICK_RX;
            st.lines   <= 4'h0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // baud generator
    // ****************************************
    baud_tick_gen u_baud (
        .REF_CLK_IN    (REF_CLK_IN),
        .RESET_IN      (RESET_IN),
        .PRESCALE_IN   (MODEM_CONTROL_IN[MCTL_PRESCALE]),
        .DIVISOR_IN    ({st.div_hi, st.div_lo}),
        .BAUD_TICK_OUT (BAUD_TICK_OUT)
    );

    assign RDATA_OUT         = st.rdata;
    assign ERROR_SUMMARY_OUT = (st.err_count != 9'h000);  // see RULE_01
    assign MODEM_IRQ_OUT     = (|st.delta) & INTERRUPT_ENABLE_IN[IEN_MODEM];  // see RULE_04
    assign TX_HALT_OUT       = st.cts_hold;  // see RULE_05
    assign RTS_N_OUT         = ~(MODEM_CONTROL_IN[MCTL_RTS] & ~st.rts_off);
    assign DIVISOR_OUT       = {st.div_hi, st.div_lo};  // see RULE_16
    assign HYSTERESIS_OUT    = hyst;
endmodule

// *** src/modem_status_pkg.sv ***
// constants, register offsets and field positions for the modem status and level block
// Notes on behaviour
// RULE_01: error summary flag is high while any stored receive byte carries an error tag.
// RULE_02: CTS, DSR and CD change flags set on any toggle since the last read.
// RULE_03: ring change flag sets only on a low-to-high ring input edge.
// RULE_04: any change flag with modem interrupt enable raises the modem interrupt request.
// RULE_05: auto CTS halts transmit after the current character while CTS is high.
// RULE_06: status bit 4 is inverse CTS, or the RTS control bit in loopback.
// RULE_07: status bit 5 is inverse DSR, or the DTR control bit in loopback.
// RULE_08: status bit 6 is inverse ring, or modem control bit 2 in loopback.
// RULE_09: status bit 7 is inverse carrier, or modem control bit 3 in loopback.
// RULE_10: scratch register is 8-bit read/write, all ones after reset.
// RULE_11: with swap set, scratch writes go to the enhanced mode register instead.
// RULE_12: counter mode 00/10 receive, 01 transmit, 11 alternating counts.
// RULE_13: alternating mode returns receive count first, then transmit, alternating.
// RULE_14: with swap set, scratch reads return the selected fifo level.
// RULE_15: hysteresis code from extended 5:4 and feature 1:0 maps to sixteen counts; the code takes bits 5:4 from the enhanced mode register.
// RULE_16: divisor is high byte then low byte; rate is prescaled clock/16/divisor.
// RULE_17: divisor bytes reachable at data addresses only with divisor access bit set.
// RULE_18: prescaler select divides the input clock by four before the generator.
// RULE_19: auto RTS drops at trigger plus hysteresis, returns below trigger minus it.
// RULE_20: reading modem status clears the four change flags.
// RULE_21: each write of the counter mode restarts the alternating sequence at receive.
package modem_status_pkg;
    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [2:0] ADDR_DATA    = 3'h0;
    localparam logic [2:0] ADDR_IEN     = 3'h1;
    localparam logic [2:0] ADDR_LSTAT   = 3'h5;
    localparam logic [2:0] ADDR_MSTAT   = 3'h6;
    localparam logic [2:0] ADDR_SCRATCH = 3'h7;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int MCTL_DTR      = 0;
    localparam int MCTL_RTS      = 1;
    localparam int MCTL_OUT1     = 2;
    localparam int MCTL_OUT2     = 3;
    localparam int MCTL_LOOP     = 4;
    localparam int MCTL_PRESCALE = 7;
    localparam int IEN_MODEM     = 3;
    localparam int EXT_AUTO_RTS  = 6;
    localparam int EXT_AUTO_CTS  = 7;
    localparam int FCTL_SWAP     = 6;
    localparam int LCTL_DIV      = 7;
    localparam logic [7:0] SCRATCH_RESET = 8'hFF;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    localparam int PRESCALE_DIV  = 4;
    localparam int OVERSAMPLE    = 16;
    localparam logic [1:0] MODE_TX  = 2'h1;
    localparam logic [1:0] MODE_ALT = 2'h3;
    typedef logic [7:0] byte_t;
endpackage

// *** src/baud_tick_gen.sv ***
// baud generator: optional divide by four, then divisor, then divide by sixteen
module baud_tick_gen
    import modem_status_pkg::*;
(
    input  wire logic        REF_CLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic        PRESCALE_IN,
    input  wire logic [15:0] DIVISOR_IN,
    output logic             BAUD_TICK_OUT
);
    typedef struct packed {
        logic [1:0]  pre;
        logic [15:0] div;
        logic [3:0]  over;
        logic        tick;
    } gen_s;
    gen_s st;
    gen_s next_st;
    logic pre_ok;
    logic div_ok;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        pre_ok = !PRESCALE_IN || (st.pre == 2'(PRESCALE_DIV - 1));  // see RULE_18
        div_ok = 1'b0;
        if (PRESCALE_IN) begin
            next_st.pre = pre_ok ? 2'h0 : st.pre + 2'h1;
        end else begin
            next_st.pre = 2'h0;
        end
        // a zero divisor stalls the generator rather than running at full rate
        if (pre_ok && DIVISOR_IN != 16'h0000) begin
            if (st.div + 16'h0001 >= DIVISOR_IN) begin
                next_st.div = 16'h0000;
                div_ok = 1'b1;
            end else begin
                next_st.div = st.div + 16'h0001;
            end
        end
        if (div_ok) begin
            next_st.over = st.over + 4'h1;
            next_st.tick = (st.over == 4'(OVERSAMPLE - 1));  // see RULE_16
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign BAUD_TICK_OUT = st.tick;
endmodule

// *** tb/modem_status_properties.sv ***
// bound assertions on the ports of the modem status block
module modem_status_properties
    import modem_status_pkg::*;
(
    input wire logic        REF_CLK_IN,
    input wire logic        RESET_IN,
    input wire logic [2:0]  ADDR_IN,
    input wire logic        WR_IN,
    input wire logic        RD_IN,
    input wire logic [7:0]  WDATA_IN,
    input wire logic [7:0]  RDATA_OUT,
    input wire logic [7:0]  LINE_CONTROL_IN,
    input wire logic [7:0]  MODEM_CONTROL_IN,
    input wire logic [7:0]  INTERRUPT_ENABLE_IN,
    input wire logic        CTS_N_IN,
    input wire logic        DSR_N_IN,
    input wire logic        RI_N_IN,
    input wire logic        CD_N_IN,
    input wire logic        RX_ERR_PUSH_IN,
    input wire logic        RX_ERR_POP_IN,
    input wire logic        RX_FLUSH_IN,
    input wire logic        ERROR_SUMMARY_OUT,
    input wire logic        MODEM_IRQ_OUT,
    input wire logic [15:0] DIVISOR_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] line_n;
    logic [3:0] loop_view;
    logic [2:0] toggle_n;
    logic       loop_on;
    logic       status_rd;
    logic       irq_seen;
    assign line_n    = {CD_N_IN, RI_N_IN, DSR_N_IN, CTS_N_IN};
    assign toggle_n  = {CD_N_IN, DSR_N_IN, CTS_N_IN};
    assign loop_view = {MODEM_CONTROL_IN[3], MODEM_CONTROL_IN[2],
                        MODEM_CONTROL_IN[0], MODEM_CONTROL_IN[1]};
    assign loop_on   = MODEM_CONTROL_IN[MCTL_LOOP];
    assign status_rd = RD_IN && ADDR_IN == ADDR_MSTAT;
    // a masked interrupt still counts as seen: the flag is what matters here
    assign irq_seen  = MODEM_IRQ_OUT || !INTERRUPT_ENABLE_IN[IEN_MODEM];
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);
    // ****************************************
    // properties
    // ****************************************
    a_irq_masked: assert property (
        !INTERRUPT_ENABLE_IN[IEN_MODEM] |-> !MODEM_IRQ_OUT)
        else $error("modem irq raised while disabled");
    a_line_toggle: assert property (
        !loop_on && $stable(loop_on) && $changed(toggle_n) |-> ##[1:3] irq_seen)
        else $error("line toggle gave no modem irq");
    a_ring_end: assert property (!loop_on && $stable(loop_on) && $rose(RI_N_IN)
        |-> ##[1:3] irq_seen) else $error("ring end gave no modem irq");
    a_read_idle: assert property (!RD_IN |=> RDATA_OUT == ZERO_BYTE)
        else $error("read data not zero outside a read");
    a_status_live: assert property (
        status_rd && !loop_on && $stable(loop_on) && $stable(line_n) && !$past(RESET_IN)
        |=> RDATA_OUT[7:4] == ~$past(line_n))
        else $error("status bits differ from inverted lines");
    a_status_loop: assert property (
        status_rd && loop_on && $stable(loop_on) && $stable(loop_view) && !$past(RESET_IN)
        |=> RDATA_OUT[7:4] == $past(loop_view))
        else $error("loopback status differs from modem control");
    a_div_write: assert property (
        WR_IN && ADDR_IN[2:1] == 2'h0 && LINE_CONTROL_IN[LCTL_DIV]
        |=> ($past(ADDR_IN) == ADDR_IEN ? DIVISOR_OUT[15:8] : DIVISOR_OUT[7:0])
        == $past(WDATA_IN)) else $error("divisor byte not written");
    a_div_guard: assert property (
        WR_IN && ADDR_IN[2:1] == 2'h0 && !LINE_CONTROL_IN[LCTL_DIV]
        |=> $stable(DIVISOR_OUT)) else $error("divisor changed without access bit");
    a_err_push: assert property (RX_ERR_PUSH_IN && !RX_ERR_POP_IN && !RX_FLUSH_IN
        |=> ERROR_SUMMARY_OUT) else $error("error summary not set");
    a_flush_clear: assert property (
        RX_FLUSH_IN && !RX_ERR_PUSH_IN |=> !ERROR_SUMMARY_OUT)
        else $error("error summary not cleared by flush");
    c_irq_read: cover property (status_rd && MODEM_IRQ_OUT);
    c_err_gone: cover property (ERROR_SUMMARY_OUT ##1 !ERROR_SUMMARY_OUT);
    c_div_write: cover property (WR_IN && LINE_CONTROL_IN[LCTL_DIV]);
endmodule
bind modem_status_regs modem_status_properties u_props (.*);

// *** tb/modem_line_model.sv ***
// modem side: drives the four active-low handshake lines
module modem_line_model
(
    input  wire logic clk_in,
    output logic      cts_n_out,
    output logic      dsr_n_out,
    output logic      ri_n_out,
    output logic      cd_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cd_n_out, ri_n_out, dsr_n_out, cts_n_out} = 4'hF;
    // lines move only after a falling edge, so the block never samples a moving level
    task automatic put(input logic [3:0] lines);
        @(negedge clk_in);
        {cd_n_out, ri_n_out, dsr_n_out, cts_n_out} = lines;
    endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the modem status, level and divisor block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import modem_status_pkg::*;
    logic        REF_CLK_IN = 1'b0, RESET_IN = 1'b1, WR_IN = 1'b0, RD_IN = 1'b0;
    logic        RX_ERR_PUSH_IN = 1'b0, RX_ERR_POP_IN = 1'b0, RX_FLUSH_IN = 1'b0;
    logic        TX_CHAR_DONE_IN = 1'b0, CTS_N_IN, DSR_N_IN, RI_N_IN, CD_N_IN;
    logic [2:0]  ADDR_IN = 3'h0;
    logic [7:0]  WDATA_IN = 8'h00, LINE_CONTROL_IN = 8'h00, MODEM_CONTROL_IN = 8'h00;
    logic [7:0]  INTERRUPT_ENABLE_IN = 8'h00, FEATURE_CONTROL_IN = 8'h00;
    logic [7:0]  EXTENDED_FEATURE_CONTROL_IN = 8'h00, RX_TRIGGER_IN = 8'h10;
    logic [7:0]  RX_LEVEL_IN = 8'h21, TX_LEVEL_IN = 8'h43, RDATA_OUT, HYSTERESIS_OUT;
    logic        ERROR_SUMMARY_OUT, MODEM_IRQ_OUT, TX_HALT_OUT, RTS_N_OUT, BAUD_TICK_OUT;
    logic [15:0] DIVISOR_OUT;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          hy [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
    always #4 REF_CLK_IN = ~REF_CLK_IN;
    modem_status_regs u_dut (.*);
    modem_line_model u_modem (
        .clk_in    (REF_CLK_IN),
        .cts_n_out (CTS_N_IN),
        .dsr_n_out (DSR_N_IN),
        .ri_n_out  (RI_N_IN),
        .cd_n_out  (CD_N_IN)
    );
    // ****************************************
    // bus and compare helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge REF_CLK_IN);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        cyc(1);
        ADDR_IN = a;
        WDATA_IN = d;
        WR_IN = 1'b1;
        cyc(1);
        WR_IN = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        cyc(1);
        ADDR_IN = a;
        RD_IN = 1'b1;
        cyc(1);
        RD_IN = 1'b0;
        d = RDATA_OUT;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string what);
        logic [7:0] r;
        rd(a, r);
        chk(r, e, what);
    endtask
    // trailing idle cycle keeps a second pulse from landing in the same time step
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    task automatic tick_gap(output int n);
        repeat (2) begin
            cyc(1);
            for (int i = 0; i < 300 && BAUD_TICK_OUT !== 1'b1; i++) begin
                cyc(1);
            end
        end
        for (n = 1; n < 300; n++) begin
            cyc(1);
            if (BAUD_TICK_OUT === 1'b1) break;
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_scratch;
        rdc(ADDR_SCRATCH, SCRATCH_RESET, "scratch reset");
        rdc(3'h2, 8'h00, "unmapped");
        wr(ADDR_SCRATCH, 8'h5A);
        rdc(ADDR_SCRATCH, 8'h5A, "scratch rw");
        $display("scratch test done");
    endtask
    task automatic t_modem;
        logic [3:0] tbl [5] = '{4'hE, 4'hC, 4'h8, 4'h0, 4'hF};
        logic [3:0] p, n, d;
        logic [7:0] r;
        p = 4'hF;
        rdc(ADDR_MSTAT, 8'h00, "status idle");
        foreach (tbl[i]) begin
            n = tbl[i];
            d = ((p ^ n) & 4'hB) | (n & ~p & 4'h4);
            u_modem.put(n);
            cyc(3);
            INTERRUPT_ENABLE_IN = 8'h00;
            cyc(1);
            chk(MODEM_IRQ_OUT, 1'b0, "irq masked");
            INTERRUPT_ENABLE_IN = 8'h08;
            cyc(1);
            chk(MODEM_IRQ_OUT, |d, "irq");
            rdc(ADDR_MSTAT, {~n, d}, "status");
            rdc(ADDR_MSTAT, {~n, 4'h0}, "status reread");
            chk(MODEM_IRQ_OUT, 1'b0, "irq cleared");
            p = n;
        end
        for (int v = 0; v < 16; v++) begin
            MODEM_CONTROL_IN = 8'h10 | 8'(v);
            cyc(2);
            rd(ADDR_MSTAT, r);
            chk(r[7:4], {v[3], v[2], v[0], v[1]}, "loop");
        end
        MODEM_CONTROL_IN = 8'h00;
        cyc(2);
        rd(ADDR_MSTAT, r);
        chk(r, 8'h0F, "loopback exit");
        $display("modem status test done");
    endtask
    task automatic t_level;
        FEATURE_CONTROL_IN = 8'h40;
        wr(ADDR_SCRATCH, 8'h00);
        rdc(ADDR_SCRATCH, 8'h21, "rx mode");
        wr(ADDR_SCRATCH, 8'h01);
        rdc(ADDR_SCRATCH, 8'h43, "tx mode");
        wr(ADDR_SCRATCH, 8'h02);
        rdc(ADDR_SCRATCH, 8'h21, "rx mode two");
        wr(ADDR_SCRATCH, 8'h03);
        rdc(ADDR_SCRATCH, 8'h21, "alt first");
        rdc(ADDR_SCRATCH, 8'h43, "alt second");
        rdc(ADDR_SCRATCH, 8'h21, "alt third");
        wr(ADDR_SCRATCH, 8'h03);
        rdc(ADDR_SCRATCH, 8'h21, "alt restart");
        for (int c = 0; c < 16; c++) begin
            FEATURE_CONTROL_IN = 8'h40 | 8'(c & 3);
            wr(ADDR_SCRATCH, 8'((c >> 2) << 4));
            chk(HYSTERESIS_OUT, 8'(hy[c]), "hysteresis");
        end
        wr(ADDR_SCRATCH, 8'h00);
        FEATURE_CONTROL_IN = 8'h01;
        rdc(ADDR_SCRATCH, 8'h5A, "scratch kept");
        $display("level test done");
    endtask
    task automatic t_div;
        int n;
        LINE_CONTROL_IN = 8'h80;
        wr(ADDR_DATA, 8'h02);
        wr(ADDR_IEN, 8'h12);
        chk(DIVISOR_OUT, 16'h1202, "divisor pair");
        wr(ADDR_IEN, 8'h00);
        rdc(ADDR_DATA, 8'h02, "divisor low");
        LINE_CONTROL_IN = 8'h00;
        wr(ADDR_DATA, 8'h99);
        chk(DIVISOR_OUT, 16'h0002, "divisor guarded");
        rdc(ADDR_DATA, 8'h00, "data address");
        tick_gap(n);
        chk(16'(n), 16'h0020, "tick gap");
        MODEM_CONTROL_IN = 8'h80;
        tick_gap(n);
        chk(16'(n), 16'h0080, "prescaled gap");
        MODEM_CONTROL_IN = 8'h00;
        $display("divisor test done");
    endtask
    task automatic t_err;
        chk(ERROR_SUMMARY_OUT, 1'b0, "err idle");
        pulse(RX_ERR_PUSH_IN);
        pulse(RX_ERR_PUSH_IN);
        pulse(RX_ERR_POP_IN);
        chk(ERROR_SUMMARY_OUT, 1'b1, "err one left");
        rdc(ADDR_LSTAT, 8'h80, "line status err");
        pulse(RX_ERR_POP_IN);
        chk(ERROR_SUMMARY_OUT, 1'b0, "err none left");
        rdc(ADDR_LSTAT, 8'h00, "line status clear");
        pulse(RX_ERR_PUSH_IN);
        pulse(RX_FLUSH_IN);
        chk(ERROR_SUMMARY_OUT, 1'b0, "err flushed");
        $display("error summary test done");
    endtask
    task automatic t_flow;
        logic [7:0] lv [5] = '{8'h00, 8'h13, 8'h14, 8'h0C, 8'h0B};
        logic       e [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        EXTENDED_FEATURE_CONTROL_IN = 8'h80;
        cyc(2);
        chk(TX_HALT_OUT, 1'b0, "no halt mid char");
        pulse(TX_CHAR_DONE_IN);
        chk(TX_HALT_OUT, 1'b1, "halt");
        u_modem.put(4'hE);
        cyc(2);
        chk(TX_HALT_OUT, 1'b0, "resume on low");
        pulse(TX_CHAR_DONE_IN);
        chk(TX_HALT_OUT, 1'b0, "resume");
        u_modem.put(4'hF);
        EXTENDED_FEATURE_CONTROL_IN = 8'h40;
        MODEM_CONTROL_IN = 8'h02;
        foreach (lv[i]) begin
            RX_LEVEL_IN = lv[i];
            cyc(2);
            chk(RTS_N_OUT, e[i], "auto rts");
        end
        $display("flow control test done");
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge REF_CLK_IN);
        @(negedge REF_CLK_IN);
        RESET_IN = 1'b0;
        t_scratch();
        t_modem();
        t_level();
        t_div();
        t_err();
        t_flow();
        summarize();
    end
    // the full sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge REF_CLK_IN);
        mismatches++;
        summarize();
    end
endmodule
